// ---- rtl/result_buffer_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module result_buffer_dev #(
	parameter int CONV_CYCLES = 83,
	parameter int WAKE_WAIT = result_buffer_pkg::WAKE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	result_link_if.dev link,
	input wire logic [2:0] num_channels,
	input wire logic [11:0] sample_in,
	input wire logic sample_valid,
	output logic sample_ready,
	output logic standby_active,
	output logic awake
);
	localparam int DW = result_buffer_pkg::DATA_W;
	localparam int PW = result_buffer_pkg::PTR_W;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_DONE = 2'h2
	} conv_state_t;
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [DW-1:0] regs_r [result_buffer_pkg::NUM_REGS]; // result store
	conv_state_t state_r;
	logic [PW-1:0] ptr_r; // read pointer
	logic [PW-1:0] wr_idx_r; // register to fill next
	logic [2:0] filled_r; // results stored so far in this sequence
	logic [2:0] seq_len_r; // channels in this sequence
	logic [7:0] cnt_r; // conversion timer
	logic [7:0] wake_r; // wake-up timer
	logic rd_n_d_r; // delayed read strobe
	logic cs_n_d_r;
	logic conv_n_d_r;
	logic standby_r;
	logic awake_r;
	logic busy_r;
	logic eoc_n_r;
	logic flag_r;
	logic pend_r; // read edge waiting for the next result to land
	logic [DW-1:0] bus_r;
	logic oe_n_r;
	logic fifo_valid;
	logic [DW-1:0] fifo_data;
	logic conv_end;
	logic read_rise;
	logic [PW-1:0] last_idx;
	assign last_idx = PW'(seq_len_r - 3'h1);
	assign read_rise = !rd_n_d_r && link.rd_n && !cs_n_d_r;
	// converted samples queue ahead of the result registers
	assign conv_end = (state_r == ST_CONV) && (cnt_r == 8'h00) &&
		fifo_valid;
	result_fifo #(.WIDTH(DW), .DEPTH(16)) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_in),
		.out_valid(fifo_valid),
		.out_ready(conv_end),
		.out_data(fifo_data)
	);
	// ----------------------------------------------------------------
	// standby and wake-up
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			standby_r <= 1'b0;
			awake_r <= 1'b0;
			wake_r <= 8'h00;
		end else begin
			standby_r <= !link.standby_n_input;
			if (!link.standby_n_input) begin
				awake_r <= 1'b0;
				wake_r <= 8'h00;
			end else if (wake_r < 8'(WAKE_WAIT)) begin
				wake_r <= wake_r + 8'h01;
			end else begin
				awake_r <= 1'b1;
			end
		end
	end
	// ----------------------------------------------------------------
	// conversion sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
			conv_n_d_r <= 1'b1;
			seq_len_r <= 3'h4;
			filled_r <= 3'h0;
			busy_r <= 1'b0;
			eoc_n_r <= 1'b1;
		end else begin
			conv_n_d_r <= link.conversion_start_n;
			eoc_n_r <= 1'b1;
			unique case (state_r)
				ST_IDLE: begin
					// rising edge of start begins a sequence
					if (!conv_n_d_r && link.conversion_start_n &&
						awake_r && num_channels != 3'h0) begin
						state_r <= ST_CONV;
						seq_len_r <= (num_channels > 3'h4) ? 3'h4 :
							num_channels;
						filled_r <= 3'h0;
						cnt_r <= 8'(CONV_CYCLES - 1);
						busy_r <= 1'b1;
					end
				end
				ST_CONV: begin
					if (cnt_r != 8'h00) begin
						cnt_r <= cnt_r - 8'h01;
					end else if (fifo_valid) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					eoc_n_r <= 1'b0;
					filled_r <= filled_r + 3'h1;
					if (filled_r + 3'h1 == seq_len_r) begin
						state_r <= ST_IDLE;
						busy_r <= 1'b0;
					end else begin
						state_r <= ST_CONV;
						cnt_r <= 8'(CONV_CYCLES - 1);
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// result registers, written a cycle before the done strobe falls
	// ----------------------------------------------------------------
	// result store, no reset so it maps onto plain storage
	always_ff @(posedge clk_sys) begin
		if (conv_end) begin
			regs_r[wr_idx_r] <= fifo_data;
		end
	end
	// fill index, back to register 0 after the last result
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_idx_r <= '0;
		end else if (conv_end) begin
			wr_idx_r <= (filled_r + 3'h1 == seq_len_r) ? '0 :
				wr_idx_r + 1'b1;
		end
	end
	// ----------------------------------------------------------------
	// read pointer and first-result flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ptr_r <= result_buffer_pkg::PTR_FIRST;
			flag_r <= 1'b1;
			pend_r <= 1'b0;
			rd_n_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
		end else begin
			rd_n_d_r <= link.rd_n;
			cs_n_d_r <= link.cs_n;
			if (conv_end && filled_r == 3'h0) begin
				ptr_r <= result_buffer_pkg::PTR_FIRST;
				flag_r <= 1'b1;
				pend_r <= 1'b0;
			end else if (conv_end && pend_r && ptr_r + 1'b1 == wr_idx_r) begin
				// deferred advance once the wanted result is stored
				ptr_r <= wr_idx_r;
				flag_r <= 1'b0;
				pend_r <= 1'b0;
			end else if (read_rise && ptr_r == last_idx) begin
				ptr_r <= result_buffer_pkg::PTR_FIRST;
				flag_r <= 1'b1;
				pend_r <= 1'b0;
			end else if (read_rise && (!busy_r ||
				3'(ptr_r) + 3'h1 < filled_r)) begin
				ptr_r <= ptr_r + 1'b1;
				flag_r <= 1'b0;
			end else if (read_rise) begin
				// next result not in yet: move when it lands
				pend_r <= 1'b1;
			end
		end
	end
	// ----------------------------------------------------------------
	// bus drive, kept alive in standby
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			oe_n_r <= 1'b1;
			bus_r <= '0;
		end else begin
			oe_n_r <= link.cs_n || link.rd_n;
			bus_r <= regs_r[ptr_r];
		end
	end
	assign link.busy = busy_r;
	assign link.eoc_n = eoc_n_r;
	assign link.first_result_flag = flag_r;
	assign link.result_bus_out = bus_r;
	assign link.result_bus_oe_n = oe_n_r;
	assign standby_active = standby_r;
	assign awake = awake_r;
endmodule
`default_nettype wire

// ---- shared/result_buffer_pkg.sv ----
`default_nettype none
package result_buffer_pkg;
	localparam int DATA_W = 12;
	localparam int NUM_REGS = 4;
	localparam int PTR_W = 2;
	localparam int CLK_PERIOD_NS = 20;
	// wake-up after standby release, external or short internal standby
	localparam int WAKE_TIME_NS = 2000;
	localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	// standby longer than this needs the long wake-up
	localparam int LONG_STANDBY_N_INPUT_NS = 1000000;
	localparam int LONG_STANDBY_N_INPUT_CYCLES = LONG_STANDBY_N_INPUT_NS / CLK_PERIOD_NS;
	// power-up settle with internal reference
	localparam int POWERUP_NS = 6000000;
	localparam int POWERUP_CYCLES = POWERUP_NS / CLK_PERIOD_NS;
	localparam logic [PTR_W-1:0] PTR_FIRST = 2'h0;
	localparam logic [11:0] CODE_MAX_POS = 12'h7FF;
	localparam logic [11:0] CODE_MAX_NEG = 12'h800;
endpackage
`default_nettype wire

// ---- shared/result_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface result_link_if;
	logic standby_n_input;
	logic conversion_start_n;
	logic cs_n;
	logic rd_n;
	logic busy;
	logic eoc_n;
	logic first_result_flag;
	logic [11:0] result_bus_out;
	logic result_bus_oe_n;
	// wire level of the result bus, resolved from the enable
	logic [11:0] result_bus;
	assign result_bus = result_bus_oe_n ? 12'hFFF : result_bus_out;
	modport dev(
		input standby_n_input, conversion_start_n, cs_n, rd_n,
		output busy, eoc_n, first_result_flag, result_bus_out,
		output result_bus_oe_n
	);
	modport host(
		output standby_n_input, conversion_start_n, cs_n, rd_n,
		input busy, eoc_n, first_result_flag, result_bus
	);
endinterface
`default_nettype wire

// ---- rtl/result_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	logic push;
	logic pop;
	assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign out_valid = wr_r != rd_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_r[AW-1:0]];
	// storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end
	// pointers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/result_buffer_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host end: starts sequences, sleeps between them, reads results
module result_buffer_host #(
	parameter int WAKE_WAIT = result_buffer_pkg::WAKE_CYCLES,
	parameter int POWERUP_WAIT = result_buffer_pkg::POWERUP_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	result_link_if.host link,
	input wire logic start_req,
	input wire logic sleep_between,
	output logic [11:0] rd_data,
	output logic rd_valid,
	output logic ready
);
	typedef enum logic [3:0] {
		H_POWER = 4'h0,
		H_IDLE = 4'h1,
		H_WAKE = 4'h2,
		H_START = 4'h3,
		H_BUSY = 4'h4,
		H_READ = 4'h5,
		H_RISE = 4'h6,
		H_HOLD = 4'h7,
		H_GAP = 4'h8
	} host_state_t;
	host_state_t state_r;
	logic [23:0] cnt_r; // wait timer
	logic standby_n_input_n_r;
	logic conv_n_r;
	logic rd_n_r;
	logic [11:0] data_r;
	logic valid_r;
	logic ready_r;
	logic first_r;
	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= H_POWER;
			cnt_r <= '0;
			standby_n_input_n_r <= 1'b1;
			conv_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			data_r <= '0;
			valid_r <= 1'b0;
			ready_r <= 1'b0;
			first_r <= 1'b0;
		end else begin
			valid_r <= 1'b0;
			conv_n_r <= 1'b1;
			unique case (state_r)
				H_POWER: begin
					// power-up settle; flag not trusted here
					if (cnt_r == 24'(POWERUP_WAIT)) begin
						state_r <= H_IDLE;
						ready_r <= 1'b1;
					end else begin
						cnt_r <= cnt_r + 24'h1;
					end
				end
				H_IDLE: begin
					if (start_req) begin
						standby_n_input_n_r <= 1'b1;
						cnt_r <= '0;
						ready_r <= 1'b0;
						state_r <= H_WAKE;
					end
				end
				H_WAKE: begin
					if (cnt_r == 24'(WAKE_WAIT)) begin
						conv_n_r <= 1'b0;
						state_r <= H_START;
					end else begin
						cnt_r <= cnt_r + 24'h1;
					end
				end
				H_START: begin
					// wait until the device has taken the start
					if (link.busy) begin
						state_r <= H_BUSY;
					end
				end
				H_BUSY: begin
					if (!link.busy) begin
						first_r <= 1'b1;
						state_r <= H_READ;
						if (sleep_between) begin
							standby_n_input_n_r <= 1'b0;
						end
					end
				end
				H_READ: begin
					// stop once pointer wrapped to the first result
					if (link.first_result_flag && !first_r) begin
						state_r <= H_IDLE;
						ready_r <= 1'b1;
					end else begin
						// reads continue in standby
						rd_n_r <= 1'b0;
						state_r <= H_HOLD;
					end
				end
				H_HOLD: begin
					// bus output is registered, data stands a cycle later
					state_r <= H_RISE;
				end
				H_RISE: begin
					rd_n_r <= 1'b1;
					data_r <= link.result_bus;
					valid_r <= 1'b1;
					first_r <= 1'b0;
					state_r <= H_GAP;
				end
				H_GAP: begin
					// let the pointer move before the flag is looked at
					state_r <= H_READ;
				end
				default: begin
					state_r <= H_IDLE;
				end
			endcase
		end
	end
	assign link.standby_n_input = standby_n_input_n_r;
	assign link.conversion_start_n = conv_n_r;
	assign link.cs_n = rd_n_r;
	assign link.rd_n = rd_n_r;
	assign rd_data = data_r;
	assign rd_valid = valid_r;
	assign ready = ready_r;
endmodule
`default_nettype wire

// ---- test/result_buffer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// link checker between the two ends
// ---------------------------------------------
module result_buffer_properties (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic standby_n_input,
	input wire logic conversion_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic busy,
	input wire logic eoc_n,
	input wire logic first_result_flag,
	input wire logic [11:0] result_bus_out,
	input wire logic result_bus_oe_n
);
	// two cycles slack for where each end counts from
	localparam int WAKE_MIN = result_buffer_pkg::WAKE_CYCLES - 2;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [2:0] eoc_cnt_r; // done strobes in this sequence
	logic [7:0] wake_cnt_r; // cycles since standby release
	logic slept_r; // standby has been used once
	// count done strobes, cleared between sequences
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			eoc_cnt_r <= 3'h0;
		end else if (!busy) begin
			eoc_cnt_r <= 3'h0;
		end else if (!eoc_n) begin
			eoc_cnt_r <= eoc_cnt_r + 3'h1;
		end
	end
	// saturating count of awake time
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wake_cnt_r <= 8'h00;
		end else if (!standby_n_input) begin
			wake_cnt_r <= 8'h00;
		end else if (wake_cnt_r != 8'hFF) begin
			wake_cnt_r <= wake_cnt_r + 8'h01;
		end
	end
	// remember a standby period
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			slept_r <= 1'b0;
		end else if (!standby_n_input) begin
			slept_r <= 1'b1;
		end
	end
	sequence s_read_on;
		!cs_n && !rd_n;
	endsequence
	sequence s_start_edge;
		$past(!conversion_start_n) && conversion_start_n;
	endsequence
	a_bus_drive_read: assert property ($past(!cs_n && !rd_n) |->
		!result_bus_oe_n) else $error("bus not driven in read");
	a_bus_release_idle: assert property ($past(cs_n || rd_n) |->
		result_bus_oe_n) else $error("bus driven outside read");
	a_eoc_one_pulse: assert property ($fell(eoc_n) |=> eoc_n)
		else $error("done strobe too long");
	a_eoc_in_seq: assert property (!eoc_n |-> busy || $past(busy))
		else $error("done strobe outside sequence");
	a_busy_end_eoc: assert property ($fell(busy) |->
		!eoc_n || $past(!eoc_n)) else $error("busy fell without done");
	a_flag_first_eoc: assert property ((!eoc_n && eoc_cnt_r == 3'h0)
		|-> first_result_flag) else $error("first flag low at first done");
	a_sleep_when_idle: assert property ($fell(standby_n_input)
		|-> !busy) else $error("standby during sequence");
	a_no_conv_standby: assert property ($rose(busy) |->
		standby_n_input) else $error("sequence in standby");
	a_seq_bounded: assert property ($rose(busy) |-> ##[1:200] !busy)
		else $error("sequence never ended");
	a_wake_wait: assert property ((s_start_edge ##0 slept_r) |->
		wake_cnt_r >= WAKE_MIN) else $error("start too soon after wake");
	a_bus_hold_read: assert property (($past(!cs_n && !rd_n, 2) &&
		$past(!cs_n && !rd_n) && !busy && $past(!busy)) |->
		$stable(result_bus_out)) else $error("bus changed within a read");
	c_read: cover property (s_read_on);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] num_channels = 3'h4;
	logic [11:0] sample_in = 12'h000;
	logic sample_valid = 1'b0;
	logic sample_ready, standby_active, awake;
	logic start_req = 1'b0;
	logic sleep_between = 1'b0;
	logic [11:0] rd_data;
	logic rd_valid, ready;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	logic saw_sleep = 1'b0; // standby was entered
	logic [11:0] got[$]; // words read by the host end
	logic [11:0] sent[$]; // words fed to the device end
	result_link_if link();
	result_buffer_dev #(.CONV_CYCLES(4)) result_buffer_dev_i(.clk_sys(clk_sys),
		.nrst(nrst), .link(link), .num_channels(num_channels),
		.sample_in(sample_in), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .standby_active(standby_active),
		.awake(awake));
	result_buffer_host #(.POWERUP_WAIT(10)) result_buffer_host_i(
		.clk_sys(clk_sys), .nrst(nrst), .link(link), .start_req(start_req),
		.sleep_between(sleep_between), .rd_data(rd_data),
		.rd_valid(rd_valid), .ready(ready));
	result_buffer_properties result_buffer_properties_i(.clk_sys(clk_sys),
		.nrst(nrst), .standby_n_input(link.standby_n_input),
		.conversion_start_n(link.conversion_start_n), .cs_n(link.cs_n),
		.rd_n(link.rd_n), .busy(link.busy), .eoc_n(link.eoc_n),
		.first_result_flag(link.first_result_flag),
		.result_bus_out(link.result_bus_out),
		.result_bus_oe_n(link.result_bus_oe_n));
	always #10 clk_sys = ~clk_sys;
	// collect reads mid-cycle, note standby, cut a hang short
	always @(negedge clk_sys) begin
		cyc = cyc + 1;
		if (rd_valid === 1'b1) got.push_back(rd_data);
		if (standby_active === 1'b1) saw_sleep = 1'b1;
		if (cyc > 20000) begin
			err_total++;
			results();
		end
	end
	task automatic chk(input string what, input logic [11:0] exp,
		input logic [11:0] seen);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", what, exp, seen);
		end
	endtask
	// offer one word and hold it until taken
	task automatic push(input logic [11:0] v);
		sample_in = v;
		sample_valid = 1'b1;
		while (sample_ready !== 1'b1) begin
			@(posedge clk_sys);
			#2;
		end
		@(posedge clk_sys);
		#2 sent.push_back(v);
	endtask
	// one sequence of n conversions, read back and judged
	task automatic run_seq(input logic [2:0] n);
		int k;
		num_channels = n;
		got.delete();
		for (k = 0; k < 500 && ready !== 1'b1; k++) begin
			@(posedge clk_sys);
			#2;
		end
		start_req = 1'b1;
		for (k = 0; k < 500 && link.busy !== 1'b1; k++) begin
			@(posedge clk_sys);
			#2;
		end
		chk("awake", 12'h001, {11'h0, awake});
		start_req = 1'b0;
		for (k = 0; k < 3000 && got.size() < n; k++) @(posedge clk_sys);
		repeat (3) @(posedge clk_sys);
		#2 chk("read count", 12'(n), 12'(got.size()));
		for (k = 0; k < n; k++) chk("word", sent.pop_front(), got[k]);
		chk("flag wrap", 12'h001, {11'h0, link.first_result_flag});
	endtask
	// fill the buffer to refusal, then drain by four sequences
	task automatic t_fill();
		int k;
		for (k = 0; k < 16; k++) push(k < 2 ? 12'h7FF + 12'(k) : 12'(k * 257));
		sample_in = 12'h5A5;
		repeat (4) @(posedge clk_sys);
		#2 chk("full refuse", 12'h000, {11'h0, sample_ready});
		sample_valid = 1'b0;
		for (k = 0; k < 4; k++) run_seq(3'h4);
	endtask
	// short channel subsets wrap at their own last register
	task automatic t_short();
		int n;
		int k;
		for (n = 1; n < 4; n++) begin
			for (k = 0; k < n; k++) push(12'(n * 256 + k));
			sample_valid = 1'b0;
			run_seq(3'(n));
		end
	endtask
	// sleep between sequences, results still readable
	task automatic t_standby();
		int r;
		sleep_between = 1'b1;
		for (r = 0; r < 2; r++) begin
			push(12'hF00 + 12'(r));
			push(12'h0F0 + 12'(r));
			sample_valid = 1'b0;
			run_seq(3'h2);
			chk("standby", 12'h001, {11'h0, standby_active});
			chk("awake off", 12'h000, {11'h0, awake});
		end
		chk("standby seen", 12'h001, {11'h0, saw_sleep});
		sleep_between = 1'b0;
	endtask
	task automatic results();
		if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		#2 nrst = 1'b1;
		t_fill();
		t_short();
		t_standby();
		results();
	end
endmodule
`default_nettype wire
